// ### design/cpm_core.sv
// Purpose: measurement sequencer, result registers and current/power arithmetic
// Assumes: register port runs on link_clk; converter codes are on the core clock
// Notes:   one register request at a time crosses by toggle handshake
// Contract
// [R1] 16-bit results readable by the host
// [R2] sense span clamps negative at -32767
// [R3] one configuration register holds all controls
// [R4] power-up mode is continuous conversion
// [R5] new sense result drives current then power
// [R6] triggered mode converts once per configuration write
// [R7] shutdown stops converting, registers stay accessible
// [R8] shutdown held until an active mode chosen
// [R9] conversion time selectable per channel
// [R10] averaging combines configured number of conversions
// [R11] current equals sense times scale over 2048
// [R12] power equals bus times current over 20000
// [R13] current and power read zero after reset
// [R14] host programs scale from shunt and step
// [R15] host picks step above max over 2^15
// [R16] signed sense and current keep sign
`timescale 1ns/1ps
`include "cpm_map.svh"
`default_nettype none
module cpm_core
	import cpm_pkg::*;
#(
	parameter int CYC_PER_US = `CPM_CLK_MHZ
) (
	// core clock and reset
	input  wire logic        clock,
	input  wire logic        rst,
	// register port on the serial link clock
	input  wire logic        link_clk,
	input  wire logic        link_req,
	input  wire logic        link_wr,
	input  wire logic [2:0]  link_addr,
	input  wire logic [15:0] link_wdata,
	output logic             link_ready,
	output logic [15:0]      link_rdata,
	output logic             link_done,
	// converter front end
	input  wire logic [15:0] adc_sense_code,
	input  wire logic [15:0] adc_bus_code,
	output logic             adc_run,
	output logic             adc_chan_bus,
	output logic             adc_take
);
	// link domain state
	logic        lk_busy_reg, lk_busy_next;   // request in flight
	logic        lk_tog_reg, lk_tog_next;     // request toggle
	logic        lk_wr_reg, lk_wr_next;       // held request kind
	logic [2:0]  lk_addr_reg, lk_addr_next;   // held index
	logic [15:0] lk_wdata_reg, lk_wdata_next; // held write data
	logic [15:0] lk_rdata_reg, lk_rdata_next; // returned read data
	logic        lk_done_reg, lk_done_next;   // completion pulse
	logic        ack_s1_reg, ack_s2_reg, ack_s3_reg; // ack synchroniser
	logic        ack_seen_reg, ack_seen_next;
	logic        ack_event;

	// core domain handshake state
	logic        req_s1_reg, req_s2_reg, req_s3_reg; // request synchroniser
	logic        req_seen_reg, req_seen_next;
	logic        req_event;
	logic        ack_tog_reg, ack_tog_next;
	logic [15:0] rdata_reg, rdata_next;           // read data held for link

	// registers and sequencer
	cpm_word_t   cfg_reg, cfg_next;
	cpm_word_t   scale_reg, scale_next;
	cpm_word_t   sense_reg, sense_next;
	cpm_word_t   busv_reg, busv_next;
	cpm_word_t   curr_reg, curr_next;
	cpm_word_t   power_reg, power_next;
	cpm_seq_e    state_reg, state_next;
	logic [23:0] cnt_reg, cnt_next;      // conversion time counter
	logic [9:0]  avg_cnt_reg, avg_cnt_next;

	// decoded configuration
	logic        sh_en, bus_en, cont_mode, active;
	logic [3:0]  avg_shift;
	logic [9:0]  avg_last;
	logic [23:0] sense_cyc, bus_cyc;
	logic        wr_cfg, wr_scale, soft_reset, restart;

	// arithmetic
	logic signed [15:0] new_sense;
	logic signed [32:0] curr_prod;
	logic signed [21:0] curr_shr;
	logic signed [15:0] new_curr;
	logic signed [32:0] pow_prod;
	logic        [32:0] pow_mag;
	logic        [32:0] pow_quot;

	cpm_avg_if avg_sense ();
	cpm_avg_if avg_bus ();

	// averaging channels, one per measured quantity
	cpm_avg_channel u_avg_sense (
		.clock (clock),
		.rst   (rst),
		.avg   (avg_sense.chan)
	);
	cpm_avg_channel u_avg_bus (
		.clock (clock),
		.rst   (rst),
		.avg   (avg_bus.chan)
	);

	// conversion time code to core cycles
	function automatic logic [23:0] conv_cycles(input logic [2:0] code);
		int us;
		unique case (code)
			3'h0: us = `CPM_CT_US_0;
			3'h1: us = `CPM_CT_US_1;
			3'h2: us = `CPM_CT_US_2;
			3'h3: us = `CPM_CT_US_3;
			3'h4: us = `CPM_CT_US_4;
			3'h5: us = `CPM_CT_US_5;
			3'h6: us = `CPM_CT_US_6;
			3'h7: us = `CPM_CT_US_7;
		endcase
		return 24'(us * CYC_PER_US);
	endfunction

	// averaging code to log2 of sample count
	function automatic logic [3:0] avg_log2(input logic [2:0] code);
		unique case (code)
			3'h0: return 4'h0;
			3'h1: return 4'h2;
			3'h2: return 4'h4;
			3'h3: return 4'h6;
			3'h4: return 4'h7;
			3'h5: return 4'h8;
			3'h6: return 4'h9;
			3'h7: return 4'hA;
		endcase
	endfunction

	// link side: take one request, hold it until the core answers
	always_comb begin
		lk_busy_next  = lk_busy_reg;
		lk_tog_next   = lk_tog_reg;
		lk_wr_next    = lk_wr_reg;
		lk_addr_next  = lk_addr_reg;
		lk_wdata_next = lk_wdata_reg;
		lk_rdata_next = lk_rdata_reg;
		lk_done_next  = 1'b0;
		ack_seen_next = ack_event ? ack_s3_reg : ack_seen_reg;
		if (ack_event) begin
			// core data is stable: its ack toggled in the same cycle that loaded it
			lk_busy_next  = 1'b0;
			lk_rdata_next = rdata_reg;
			lk_done_next  = 1'b1;
		end else if (link_req && !lk_busy_reg) begin
			lk_busy_next  = 1'b1;
			lk_tog_next   = ~lk_tog_reg;
			lk_wr_next    = link_wr;
			lk_addr_next  = link_addr;
			lk_wdata_next = link_wdata;
		end
	end

	// ack counts once the second and third stages agree on a new level
	assign ack_event  = (ack_s2_reg == ack_s3_reg) && (ack_s3_reg != ack_seen_reg);
	assign link_ready = !lk_busy_reg;
	assign link_rdata = lk_rdata_reg;
	assign link_done  = lk_done_reg;

	// link domain registers
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			lk_busy_reg  <= 1'b0;
			lk_tog_reg   <= 1'b0;
			lk_wr_reg    <= 1'b0;
			lk_addr_reg  <= 3'h0;
			lk_wdata_reg <= 16'h0000;
			lk_rdata_reg <= 16'h0000;
			lk_done_reg  <= 1'b0;
			ack_s1_reg   <= 1'b0;
			ack_s2_reg   <= 1'b0;
			ack_s3_reg   <= 1'b0;
			ack_seen_reg <= 1'b0;
		end else begin
			lk_busy_reg  <= lk_busy_next;
			lk_tog_reg   <= lk_tog_next;
			lk_wr_reg    <= lk_wr_next;
			lk_addr_reg  <= lk_addr_next;
			lk_wdata_reg <= lk_wdata_next;
			lk_rdata_reg <= lk_rdata_next;
			lk_done_reg  <= lk_done_next;
			ack_s1_reg   <= ack_tog_reg;
			ack_s2_reg   <= ack_s1_reg;
			ack_s3_reg   <= ack_s2_reg;
			ack_seen_reg <= ack_seen_next;
		end
	end

	// core side request detection; held fields are stable while busy
	assign req_event  = (req_s2_reg == req_s3_reg) && (req_s3_reg != req_seen_reg);
	assign wr_cfg     = req_event && lk_wr_reg && (lk_addr_reg == `CPM_OFS_CFG);
	assign wr_scale   = req_event && lk_wr_reg && (lk_addr_reg == `CPM_OFS_SCALE);
	assign soft_reset = wr_cfg && lk_wdata_reg[`CPM_CFG_RST_BIT];
	// [R6] trigger on write
	assign restart    = wr_cfg && !soft_reset;

	// [R3] configuration fields
	assign sh_en      = cfg_reg[`CPM_MODE_LSB];
	assign bus_en     = cfg_reg[`CPM_MODE_LSB+1];
	assign cont_mode  = cfg_reg[`CPM_MODE_LSB+2];
	// [R7] shutdown when no channel
	assign active     = sh_en || bus_en;
	// [R9] per-channel conversion time
	assign sense_cyc  = conv_cycles(cfg_reg[`CPM_SCT_LSB +: 3]);
	assign bus_cyc    = conv_cycles(cfg_reg[`CPM_BCT_LSB +: 3]);
	// [R10] averaging count
	assign avg_shift  = avg_log2(cfg_reg[`CPM_AVG_LSB +: 3]);
	assign avg_last   = 10'((11'h001 << avg_shift) - 11'h001);

	// [R2] clamp averaged sense to the span
	always_comb begin
		if (avg_sense.mean < -17'sd32767) begin
			new_sense = `CPM_SENSE_MIN;
		end else if (avg_sense.mean > 17'sd32767) begin
			new_sense = `CPM_SENSE_MAX;
		end else begin
			new_sense = avg_sense.mean[15:0];
		end
	end

	// [R11] current from new sense
	// [R16] signed product
	assign curr_prod = 33'(new_sense) * $signed({17'h00000, scale_reg});
	assign curr_shr  = curr_prod[32:11];
	always_comb begin
		if (curr_shr > 22'sd32767) begin
			new_curr = `CPM_SENSE_MAX;
		end else if (curr_shr < -22'sd32768) begin
			new_curr = 16'h8000;
		end else begin
			new_curr = curr_shr[15:0];
		end
	end

	// [R12] power magnitude over 20000
	assign pow_prod = $signed({17'h00000, busv_reg}) * 33'($signed(curr_reg));
	assign pow_mag  = pow_prod[32] ? 33'(-pow_prod) : 33'(pow_prod);
	assign pow_quot = pow_mag / 33'(`CPM_POWER_DIV);

	// sequencer, registers and read data
	always_comb begin
		state_next    = state_reg;
		cnt_next      = cnt_reg;
		avg_cnt_next  = avg_cnt_reg;
		cfg_next      = cfg_reg;
		scale_next    = scale_reg;
		sense_next    = sense_reg;
		busv_next     = busv_reg;
		curr_next     = curr_reg;
		power_next    = power_reg;
		req_seen_next = req_event ? req_s3_reg : req_seen_reg;
		ack_tog_next  = req_event ? ~ack_tog_reg : ack_tog_reg;
		rdata_next    = rdata_reg;
		adc_take      = 1'b0;
		avg_sense.clear  = 1'b0;
		avg_sense.push   = 1'b0;
		avg_bus.clear    = 1'b0;
		avg_bus.push     = 1'b0;
		// [R1] converter codes into channels
		avg_sense.sample = 17'($signed(adc_sense_code));
		avg_bus.sample   = {1'b0, adc_bus_code};
		avg_sense.shift  = avg_shift;
		avg_bus.shift    = avg_shift;
		// conversion steps
		unique case (state_reg)
			ST_IDLE: begin
				// [R4] continuous repeats unprompted
				if (cont_mode && active) begin
					state_next      = sh_en ? ST_SENSE : ST_BUS;
					cnt_next        = 24'h000000;
					avg_cnt_next    = 10'h000;
					avg_sense.clear = 1'b1;
					avg_bus.clear   = 1'b1;
				end
			end
			ST_SENSE: begin
				cnt_next = cnt_reg + 24'h000001;
				if (cnt_reg >= sense_cyc - 24'h000001) begin
					adc_take       = 1'b1;
					avg_sense.push = 1'b1;
					cnt_next       = 24'h000000;
					if (bus_en) begin
						state_next = ST_BUS;
					end else if (avg_cnt_reg >= avg_last) begin
						state_next = ST_CURR;
					end else begin
						avg_cnt_next = avg_cnt_reg + 10'h001;
					end
				end
			end
			ST_BUS: begin
				cnt_next = cnt_reg + 24'h000001;
				if (cnt_reg >= bus_cyc - 24'h000001) begin
					adc_take     = 1'b1;
					avg_bus.push = 1'b1;
					cnt_next     = 24'h000000;
					if (avg_cnt_reg >= avg_last) begin
						state_next = ST_CURR;
					end else begin
						avg_cnt_next = avg_cnt_reg + 10'h001;
						state_next   = sh_en ? ST_SENSE : ST_BUS;
					end
				end
			end
			ST_CURR: begin
				// [R5] results and current in the same step
				if (sh_en) begin
					sense_next = new_sense;
					curr_next  = new_curr;
				end
				if (bus_en) begin
					busv_next = avg_bus.mean[15:0];
				end
				state_next = sh_en ? ST_POWER : ST_IDLE;
			end
			ST_POWER: begin
				// [R5] power after current
				power_next = (pow_quot > 33'(`CPM_POWER_MAX)) ? `CPM_POWER_MAX : pow_quot[15:0];
				state_next = ST_IDLE;
			end
		endcase
		// [R6] write restarts a conversion
		// [R8] leaves shutdown only on active mode
		if (restart) begin
			cfg_next        = (lk_wdata_reg & ~`CPM_CFG_FIXED) | (`CPM_CFG_RESET & `CPM_CFG_FIXED);
			avg_sense.clear = 1'b1;
			avg_bus.clear   = 1'b1;
			avg_sense.push  = 1'b0;
			avg_bus.push    = 1'b0;
			cnt_next        = 24'h000000;
			avg_cnt_next    = 10'h000;
			if (lk_wdata_reg[`CPM_MODE_LSB])
				state_next = ST_SENSE;
			else if (lk_wdata_reg[`CPM_MODE_LSB+1])
				state_next = ST_BUS;
			else
				state_next = ST_IDLE;
		end
		if (wr_scale) begin
			scale_next = lk_wdata_reg;
		end
		// [R13] reset bit returns zeros
		if (soft_reset) begin
			cfg_next   = `CPM_CFG_RESET;
			scale_next = `CPM_SCALE_RESET;
			sense_next = `CPM_ZERO_RESET;
			busv_next  = `CPM_ZERO_RESET;
			curr_next  = `CPM_ZERO_RESET;
			power_next = `CPM_ZERO_RESET;
			state_next = ST_IDLE;
		end
		// [R7] reads served in every mode
		if (req_event && !lk_wr_reg) begin
			unique case (lk_addr_reg)
				`CPM_OFS_CFG:   rdata_next = cfg_reg;
				`CPM_OFS_SENSE: rdata_next = sense_reg;
				`CPM_OFS_BUSV:  rdata_next = busv_reg;
				`CPM_OFS_POWER: rdata_next = power_reg;
				`CPM_OFS_CURR:  rdata_next = curr_reg;
				`CPM_OFS_SCALE: rdata_next = scale_reg;
				default:        rdata_next = 16'h0000;
			endcase
		end
	end

	assign adc_run      = state_reg[1] || state_reg[2];
	assign adc_chan_bus = state_reg[2];

	// core domain registers
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			req_s1_reg   <= 1'b0;
			req_s2_reg   <= 1'b0;
			req_s3_reg   <= 1'b0;
			req_seen_reg <= 1'b0;
			ack_tog_reg  <= 1'b0;
			rdata_reg    <= 16'h0000;
			state_reg    <= ST_IDLE;
			cnt_reg      <= 24'h000000;
			avg_cnt_reg  <= 10'h000;
			cfg_reg      <= `CPM_CFG_RESET;
			scale_reg    <= `CPM_SCALE_RESET;
			sense_reg    <= `CPM_ZERO_RESET;
			busv_reg     <= `CPM_ZERO_RESET;
			curr_reg     <= `CPM_ZERO_RESET;
			power_reg    <= `CPM_ZERO_RESET;
		end else begin
			req_s1_reg   <= lk_tog_reg;
			req_s2_reg   <= req_s1_reg;
			req_s3_reg   <= req_s2_reg;
			req_seen_reg <= req_seen_next;
			ack_tog_reg  <= ack_tog_next;
			rdata_reg    <= rdata_next;
			state_reg    <= state_next;
			cnt_reg      <= cnt_next;
			avg_cnt_reg  <= avg_cnt_next;
			cfg_reg      <= cfg_next;
			scale_reg    <= scale_next;
			sense_reg    <= sense_next;
			busv_reg     <= busv_next;
			curr_reg     <= curr_next;
			power_reg    <= power_next;
		end
	end
endmodule
`default_nettype wire

// ### design/cpm_map.svh
// Purpose: register offsets, field positions, reset values and timing figures
// Assumes: 125 MHz core clock
// Notes:   definitions only
`ifndef CPM_MAP_SVH
`define CPM_MAP_SVH
// register offsets (register index on the serial register port)
`define CPM_OFS_CFG     3'h0
`define CPM_OFS_SENSE   3'h1
`define CPM_OFS_BUSV    3'h2
`define CPM_OFS_POWER   3'h3
`define CPM_OFS_CURR    3'h4
`define CPM_OFS_SCALE   3'h5
// reset values
`define CPM_CFG_RESET   16'h4127
`define CPM_SCALE_RESET 16'h0000
`define CPM_ZERO_RESET  16'h0000
// configuration fields
`define CPM_CFG_RST_BIT 15
`define CPM_CFG_FIXED   16'h7000
`define CPM_AVG_LSB     9
`define CPM_BCT_LSB     6
`define CPM_SCT_LSB     3
`define CPM_MODE_LSB    0
// arithmetic
`define CPM_CURR_SHIFT  11
`define CPM_POWER_DIV   20000
`define CPM_SENSE_MIN   16'h8001
`define CPM_SENSE_MAX   16'h7FFF
`define CPM_POWER_MAX   16'hFFFF
// conversion times in microseconds, one per time code
`define CPM_CT_US_0     139
`define CPM_CT_US_1     204
`define CPM_CT_US_2     332
`define CPM_CT_US_3     588
`define CPM_CT_US_4     1100
`define CPM_CT_US_5     2116
`define CPM_CT_US_6     4156
`define CPM_CT_US_7     8205
`define CPM_CLK_MHZ     125
`endif

// ### design/cpm_pkg.sv
// Purpose: shared types of the measurement core
// Assumes: nothing
// Notes:   constants live in cpm_map.svh
package cpm_pkg;
	// sequencer states, one-hot
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_SENSE = 5'b00010,
		ST_BUS   = 5'b00100,
		ST_CURR  = 5'b01000,
		ST_POWER = 5'b10000
	} cpm_seq_e;
	typedef logic [15:0] cpm_word_t;
endpackage

// ### design/cpm_avg_if.sv
// Purpose: carries one averaging channel between sequencer and accumulator
// Assumes: core clock domain only
// Notes:   samples are 17-bit signed so unsigned bus codes fit
`timescale 1ns/1ps
`default_nettype none
interface cpm_avg_if;
	logic               clear;  // start a new average
	logic               push;   // accumulate sample
	logic signed [16:0] sample; // converter code, sign or zero extended
	logic [3:0]         shift;  // log2 of average count
	logic signed [16:0] mean;   // accumulated sum divided by count
	modport ctrl (output clear, output push, output sample, output shift, input mean);
	modport chan (input clear, input push, input sample, input shift, output mean);
endinterface
`default_nettype wire

// ### design/cpm_avg_channel.sv
// Purpose: accumulates converter samples and yields their mean
// Assumes: count of samples is a power of two given as shift
// Notes:   sum is kept wide enough for 1024 full-scale samples
`timescale 1ns/1ps
`default_nettype none
module cpm_avg_channel
	import cpm_pkg::*;
#(
	parameter int ACC_W = 28
) (
	// clock and reset
	input  wire logic clock,
	input  wire logic rst,
	// sequencer side
	cpm_avg_if.chan   avg
);
	logic signed [ACC_W-1:0] acc_reg;  // running sum
	logic signed [ACC_W-1:0] acc_next;
	logic signed [ACC_W-1:0] acc_shr;  // sum scaled by count

	// next sum: clear restarts at zero, push adds one sample
	always_comb begin
		acc_next = acc_reg;
		if (avg.clear) begin
			acc_next = '0;
		end else if (avg.push) begin
			acc_next = acc_reg + ACC_W'(avg.sample);
		end
	end

	// arithmetic shift keeps the sign of reverse current
	assign acc_shr  = acc_reg >>> avg.shift;
	assign avg.mean = acc_shr[16:0];

	// sum register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			acc_reg <= '0;
		end else begin
			acc_reg <= acc_next;
		end
	end
endmodule
`default_nettype wire

// ### tb/cpm_core_asserts.sv
// Purpose: port-level checks of the measurement core
// Assumes: bound to cpm_core; core and register port clocks unrelated
// Notes:   each property names its own clock and reset
`timescale 1ns/1ps
`default_nettype none
module cpm_core_asserts #(
	parameter int CYC_PER_US = 125
) (
	// core domain
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic [15:0] adc_sense_code,
	input  wire logic [15:0] adc_bus_code,
	input  wire logic        adc_run,
	input  wire logic        adc_chan_bus,
	input  wire logic        adc_take,
	// register port domain
	input  wire logic        link_clk,
	input  wire logic        link_req,
	input  wire logic        link_wr,
	input  wire logic [2:0]  link_addr,
	input  wire logic [15:0] link_wdata,
	input  wire logic        link_ready,
	input  wire logic [15:0] link_rdata,
	input  wire logic        link_done
);
	// a sample is only taken inside a conversion
	property p_take_in_run; @(posedge clock) disable iff (rst) adc_take |-> adc_run; endproperty
	a_take_in_run: assert property (p_take_in_run) else $error("sample taken while idle");
	// shortest conversion is far longer than eight cycles
	property p_take_gap; @(posedge clock) disable iff (rst) adc_take |=> (!adc_take)[*8]; endproperty
	a_take_gap: assert property (p_take_gap) else $error("samples too close");
	// channel select only means something while converting
	property p_chan_in_run; @(posedge clock) disable iff (rst) adc_chan_bus |-> adc_run; endproperty
	a_chan_in_run: assert property (p_chan_in_run) else $error("bus channel while idle");
	// power-up default is continuous, so conversion starts at once
	property p_run_after_reset; @(posedge clock) disable iff (rst) $fell(rst) |-> ##[0:2] adc_run;
	endproperty
	a_run_after_reset: assert property (p_run_after_reset) else $error("no conversion after reset");
	// completion is a single cycle pulse
	property p_done_pulse; @(posedge link_clk) disable iff (rst) link_done |=> !link_done; endproperty
	a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");
	// an accepted request closes the port
	property p_ready_drop;
		@(posedge link_clk) disable iff (rst) link_req && link_ready |=> !link_ready;
	endproperty
	a_ready_drop: assert property (p_ready_drop) else $error("port open while busy");
	// every accepted request completes in bounded time; closed port is a_ready_drop
	property p_done_bound;
		@(posedge link_clk) disable iff (rst) link_req && link_ready |-> ##[1:20] link_done;
	endproperty
	a_done_bound: assert property (p_done_bound) else $error("request never completed");
	// port reopens together with completion
	property p_done_ready; @(posedge link_clk) disable iff (rst) link_done |-> link_ready; endproperty
	a_done_ready: assert property (p_done_ready) else $error("done while still busy");
	// read data only moves at a completion
	property p_rdata_hold;
		@(posedge link_clk) disable iff (rst) !link_done |-> $stable(link_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without done");
	// main scenarios reached
	c_bus_take: cover property (@(posedge clock) disable iff (rst) adc_take && adc_chan_bus);
	c_pass_end: cover property (@(posedge clock) disable iff (rst) $fell(adc_run));
	c_read_done: cover property (@(posedge link_clk) disable iff (rst) link_done && !link_wr);
endmodule
`default_nettype wire

// ### tb/cpm_host_model.sv
// Purpose: register port host, one request at a time
// Assumes: requests launched and released on link_clk rising edges
// Notes:   released address and data lines show inverted garbage
`timescale 1ns/1ps
`default_nettype none
module cpm_host_model (
	// port clock
	input  wire logic        link_clk,
	// request side
	output logic             link_req,
	output logic             link_wr,
	output logic [2:0]       link_addr,
	output logic [15:0]      link_wdata,
	// answer side
	input  wire logic        link_ready,
	input  wire logic [15:0] link_rdata,
	input  wire logic        link_done
);
	// idle port at time zero
	initial begin
		link_req   = 1'b0;
		link_wr    = 1'b0;
		link_addr  = 3'h7;
		link_wdata = 16'hA5A5;
	end
	function automatic real step_for(real imax_a);
		return $ceil(imax_a / 32768.0 * 1000.0) / 1000.0;
	endfunction
	function automatic logic [15:0] scale_for(real r_ohm, real step_a);
		return 16'($rtoi(0.00512 / (r_ohm * step_a) + 0.5));
	endfunction
	// one transfer; ok low if the port never took or never answered
	task automatic xfer(input logic wr, input logic [2:0] a, input logic [15:0] d,
		output logic [15:0] q, output logic ok);
		int   n;
		logic taken;
		taken = 1'b0;
		ok = 1'b0;
		q = 16'h0000;
		@(posedge link_clk);
		link_req   <= 1'b1;
		link_wr    <= wr;
		link_addr  <= a;
		link_wdata <= d;
		// hold everything until ready is seen at an edge
		for (n = 0; n < 20 && !taken; n++) begin
			@(posedge link_clk);
			taken = (link_ready === 1'b1);
		end
		// released lines must not look valid
		link_req   <= 1'b0;
		link_addr  <= ~a;
		link_wdata <= ~d;
		for (n = 0; n < 40 && taken && !ok; n++) begin
			@(posedge link_clk);
			ok = (link_done === 1'b1);
		end
		if (ok) q = link_rdata;
	endtask
endmodule
`default_nettype wire

// ### tb/tb.sv
// Purpose: self-checking bench of the measurement core
// Assumes: core at 125 MHz, register port at 30 ns, one cycle per microsecond
// Notes:   short conversion codes keep single-sample passes near 300 cycles
`timescale 1ns/1ps
`include "cpm_map.svh"
`default_nettype none
module tb;
	import cpm_pkg::*;
	localparam logic [15:0] CFG_FAST = 16'h4007; // continuous, shortest times
	localparam logic [15:0] CFG_TRIG = 16'h4203; // triggered, four averages
	localparam logic [15:0] CFG_OFF  = 16'h4000; // shutdown
	logic        clock, rst, link_clk, ramp;
	logic        link_req, link_wr, link_ready, link_done;
	logic [2:0]  link_addr;
	logic [15:0] link_wdata, link_rdata, adc_sense_code, adc_bus_code;
	logic        adc_run, adc_chan_bus, adc_take;
	int          fails, n_tests;
	// clocks never share a rising edge
	always #4 clock = ~clock;
	always #15 link_clk = ~link_clk;
	cpm_core #(.CYC_PER_US(1)) dut (.clock(clock), .rst(rst), .link_clk(link_clk),
		.link_req(link_req), .link_wr(link_wr), .link_addr(link_addr), .link_wdata(link_wdata),
		.link_ready(link_ready), .link_rdata(link_rdata), .link_done(link_done),
		.adc_sense_code(adc_sense_code), .adc_bus_code(adc_bus_code), .adc_run(adc_run),
		.adc_chan_bus(adc_chan_bus), .adc_take(adc_take));
	cpm_host_model host (.link_clk(link_clk), .link_req(link_req), .link_wr(link_wr),
		.link_addr(link_addr), .link_wdata(link_wdata), .link_ready(link_ready),
		.link_rdata(link_rdata), .link_done(link_done));
	// sense code climbs after each sense sample, so the mean is known
	always @(posedge clock) begin
		if (ramp && adc_take && !adc_chan_bus) adc_sense_code <= adc_sense_code + 16'h0010;
	end
	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(logic [2:0] a, logic [15:0] d);
		logic [15:0] q;
		logic        ok;
		host.xfer(1'b1, a, d, q, ok);
		check("write handshake", {15'h0000, ok}, 16'h0001);
	endtask
	task automatic rd(string what, logic [2:0] a, logic [15:0] exp);
		logic [15:0] q;
		logic        ok;
		host.xfer(1'b0, a, 16'h0000, q, ok);
		check(what, (ok === 1'b1) ? q : 16'hXXXX, exp);
	endtask
	task automatic set_codes(logic [15:0] s, logic [15:0] b);
		@(posedge clock);
		adc_sense_code <= s;
		adc_bus_code   <= b;
	endtask
	// wait for a conversion pass to start and end, then let results land
	task automatic wait_pass();
		int n;
		for (n = 0; n < 3000 && adc_run !== 1'b1; n++) @(posedge clock);
		check("pass start", {15'h0000, adc_run}, 16'h0001);
		for (n = 0; n < 6000 && adc_run !== 1'b0; n++) @(posedge clock);
		check("pass end", {15'h0000, adc_run}, 16'h0000);
		repeat (4) @(posedge clock);
	endtask
	task automatic quiet(int cycles);
		int hits;
		hits = 0;
		repeat (cycles) begin
			@(posedge clock);
			if (adc_run !== 1'b0) hits++;
		end
		check("idle conversions", 16'(hits), 16'h0000);
	endtask
	function automatic int cur(int s, int k);
		return (s * k) >>> 11;
	endfunction
	// power magnitude, clipped to the register
	function automatic logic [15:0] pow(int b, int c);
		int p;
		p = b * (c < 0 ? -c : c) / `CPM_POWER_DIV;
		return (p > 65535) ? 16'hFFFF : 16'(p);
	endfunction
	task automatic t_defaults();
		rd("config", `CPM_OFS_CFG, `CPM_CFG_RESET);
		rd("scale", `CPM_OFS_SCALE, 16'h0000);
		rd("current", `CPM_OFS_CURR, 16'h0000);
		rd("power", `CPM_OFS_POWER, 16'h0000);
		rd("unmapped", 3'h6, 16'h0000);
	endtask
	task automatic t_calc();
		int k;
		k = int'(host.scale_for(0.002, host.step_for(10.0)));
		set_codes(16'h1F40, 16'h2580);
		wr(`CPM_OFS_SCALE, 16'(k));
		wr(`CPM_OFS_CFG, CFG_FAST);
		wait_pass();
		rd("sense", `CPM_OFS_SENSE, 16'h1F40);
		rd("bus", `CPM_OFS_BUSV, 16'h2580);
		rd("current", `CPM_OFS_CURR, 16'(cur(8000, k)));
		rd("power", `CPM_OFS_POWER, pow(9600, cur(8000, k)));
		// reverse current, new codes picked up without host help
		set_codes(16'hE0C0, 16'h2580);
		wait_pass();
		wait_pass();
		rd("neg current", `CPM_OFS_CURR, 16'(cur(-8000, k)));
		rd("neg power", `CPM_OFS_POWER, pow(9600, cur(-8000, k)));
		set_codes(16'h8000, 16'h2580);
		wait_pass();
		wait_pass();
		rd("clamped sense", `CPM_OFS_SENSE, 16'h8001);
	endtask
	task automatic t_shut();
		wr(`CPM_OFS_CFG, CFG_OFF);
		quiet(50);
		quiet(400);
		wr(`CPM_OFS_SCALE, 16'h1357);
		rd("scale", `CPM_OFS_SCALE, 16'h1357);
		rd("config", `CPM_OFS_CFG, CFG_OFF);
	endtask
	task automatic t_trig();
		set_codes(16'h0100, 16'h0200);
		ramp <= 1'b1;
		wr(`CPM_OFS_CFG, CFG_TRIG);
		wait_pass();
		ramp <= 1'b0;
		rd("mean", `CPM_OFS_SENSE, 16'h0118);
		set_codes(16'h0050, 16'h0200);
		quiet(600);
		rd("held", `CPM_OFS_SENSE, 16'h0118);
		wr(`CPM_OFS_CFG, CFG_TRIG);
		wait_pass();
		rd("fresh", `CPM_OFS_SENSE, 16'h0050);
	endtask
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_tests, fails);
		if (fails == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// hang guard
	initial begin
		repeat (60000) @(posedge clock);
		fails++;
		stop_test();
	end
	initial begin
		clock = 1'b0;
		link_clk = 1'b0;
		rst = 1'b1;
		ramp = 1'b0;
		adc_sense_code = 16'h0000;
		adc_bus_code = 16'h0000;
		fails = 0;
		n_tests = 0;
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_defaults();
		wr(`CPM_OFS_SENSE, 16'h1234);
		rd("read-only sense", `CPM_OFS_SENSE, 16'h0000);
		t_calc();
		t_shut();
		t_trig();
		wr(`CPM_OFS_CFG, 16'h8000);
		t_defaults();
		stop_test();
	end
endmodule
bind cpm_core cpm_core_asserts #(.CYC_PER_US(CYC_PER_US)) u_chk (.clock(clock), .rst(rst),
	.adc_sense_code(adc_sense_code), .adc_bus_code(adc_bus_code), .adc_run(adc_run),
	.adc_chan_bus(adc_chan_bus), .adc_take(adc_take), .link_clk(link_clk),
	.link_req(link_req), .link_wr(link_wr), .link_addr(link_addr), .link_wdata(link_wdata),
	.link_ready(link_ready), .link_rdata(link_rdata), .link_done(link_done));
`default_nettype wire
